// >>> rtl/mebi_top.sv
// Behaviour
// - Address latch strobe pulses once per machine cycle, as a clock.
// - Address is valid on the bus at the strobe's falling edge.
// - Fetch strobe goes low only for external program fetches.
// - External fetch drives low PC bits, reads instruction under strobe.
// - External fetch drives the four high PC bits on upper port two.
// - Data memory access places address then data, framed by strobes.
// - Read strobe goes low each bus read; outside drives only then.
// - Write strobe goes low each bus write, as memory write enable.
// - External fetch force sends every program fetch to the outside.
// - Single step low halts after the current instruction completes.
// - Interrupt starts when enabled; off after reset; input testable.
// - Reset initialises the processor and leaves power down mode.
// - Expander transfers use lower port two nibble, qualified by strobe.
// - The bus works as a strobed port or a statically latched output.
// - Test pin one is testable and feeds the event counter.
// - Power save input low saves power while in power down.
// - Instruction control can turn test pin zero into a clock output.
module mebi_top
    import mebi_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Core command, sampled at the end of each machine cycle.
    input wire logic cmdValid,
    input wire logic [2:0] cmdKind,
    input wire logic [11:0] cmdAddr,
    input wire logic [7:0] cmdData,
    input wire logic cmdLast,
    output logic cmdTaken,
    output logic [7:0] rdData,
    output logic rdValid,
    output logic coreInit,
    // Core control of interrupts, port two, test pins and power down.
    input wire logic intEnableSet,
    input wire logic intEnableClr,
    input wire logic [7:0] portTwoLatch,
    input wire logic enable_test_clock_out,
    input wire logic begin_event_counting,
    input wire logic stopEventCounting,
    input wire logic powerDownCmd,
    output logic irqRequest,
    output logic intPinLow,
    output logic t0Level,
    output logic t1Level,
    output logic eventTick,
    output logic stepWaiting,
    output logic powerDown,
    output logic oscStop,
    // Multiplexed bus and strobes.
    input wire logic [7:0] multiplexed_bus_in,
    output logic [7:0] multiplexed_bus_out,
    output logic multiplexed_bus_oe,
    output logic addressLatch,
    output logic program_fetch_strobe_n,
    output logic readStrobeN,
    output logic writeStrobeN,
    output logic expander_strobe,
    // Port two.
    output logic [7:0] port_two_pins_out,
    output logic [7:0] port_two_pins_oe,
    // Control and test pins.
    input wire logic external_fetch_force,
    input wire logic singleStepN,
    input wire logic interruptN,
    input wire logic power_save_n,
    input wire logic test_pin_zero_in,
    output logic test_pin_zero_out,
    output logic test_pin_zero_oe,
    input wire logic test_pin_one
);

    mebi_phase_e phase_r;
    logic [2:0] curKind_r;
    logic [11:0] curAddr_r;
    logic [7:0] curData_r;
    logic curExt_r;
    logic curLast_r;
    logic stepWait_r;
    logic powerDown_r;
    logic intEnable_r;
    logic irqRequest_r;
    logic intPinLow_r;
    logic [7:0] staticLatch_r;
    logic staticDrive_r;
    logic [7:0] rdData_r;
    logic rdValid_r;
    logic countMode_r;
    logic t1Prev_r;
    logic eventTick_r;
    logic t0ClkMode_r;
    logic t0Clk_r;
    logic [3:0] t0Div_r;
    logic advance;
    logic extFetch;
    logic addrCycle;
    logic busCycle;
    logic addrPhase;
    logic stbPhase;
    logic isRead;
    logic isWrite;

    // A new machine cycle starts unless single step or power down holds it.
    assign advance = !stepWait_r && !powerDown_r;
    assign cmdTaken = (phase_r == PH_REL) && advance && cmdValid;

    // Machine cycle sequencer; a wait always parks in the release phase.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            phase_r <= PH_REL;
        else
        begin
            unique case (phase_r)
                PH_ALE: phase_r <= PH_HOLD;
                PH_HOLD: phase_r <= PH_STB1;
                PH_STB1: phase_r <= PH_STB2;
                PH_STB2: phase_r <= PH_REL;
                PH_REL:
                    if (advance)
                        phase_r <= PH_ALE;
                default: phase_r <= PH_REL;
            endcase
        end
    end

    // Command capture at the machine cycle boundary.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            curKind_r <= KIND_IDLE;
            curAddr_r <= 12'h000;
            curData_r <= RST_BUS;
            curExt_r <= 1'b0;
            curLast_r <= 1'b0;
        end
        else if (phase_r == PH_REL && advance)
        begin
            curKind_r <= cmdValid ? cmdKind : KIND_IDLE;
            curAddr_r <= cmdAddr;
            curData_r <= cmdData;
            // The force input overrides the internal store for every fetch.
            curExt_r <= cmdValid && cmdKind == KIND_FETCH
                && (external_fetch_force
                || cmdAddr >= INT_EXPANDER_STROBE_LIMIT);
            curLast_r <= cmdValid && cmdLast;
        end
    end

    // Cycle classification from the captured command.
    assign extFetch = (curKind_r == KIND_FETCH) && curExt_r;
    assign addrCycle = extFetch || curKind_r == KIND_DATA_RD
        || curKind_r == KIND_DATA_WR;
    assign busCycle = addrCycle || curKind_r == KIND_PORT_RD
        || curKind_r == KIND_PORT_WR;
    assign isRead = extFetch || curKind_r == KIND_DATA_RD
        || curKind_r == KIND_PORT_RD;
    assign isWrite = curKind_r == KIND_DATA_WR || curKind_r == KIND_PORT_WR;
    assign addrPhase = addrCycle && (phase_r == PH_ALE || phase_r == PH_HOLD);
    assign stbPhase = phase_r == PH_STB1 || phase_r == PH_STB2;

    // Strobes; ALE runs in idle and internal cycles too, as a clock.
    assign addressLatch = (phase_r == PH_ALE);
    assign program_fetch_strobe_n = !(stbPhase && extFetch);
    assign readStrobeN = !(stbPhase && isRead && !extFetch);
    assign writeStrobeN = !(stbPhase && isWrite);
    assign expander_strobe = stbPhase && curKind_r == KIND_EXPAND;

    // Bus drive: address through the ALE fall, then write data under the
    // write strobe; a static latch drives only between bus cycles.
    always_comb
    begin
        multiplexed_bus_oe = 1'b0;
        multiplexed_bus_out = staticLatch_r;
        if (addrPhase)
        begin
            multiplexed_bus_oe = 1'b1;
            multiplexed_bus_out = curAddr_r[7:0];
        end
        else if (stbPhase && isWrite)
        begin
            multiplexed_bus_oe = 1'b1;
            multiplexed_bus_out = curData_r;
        end
        else if (staticDrive_r && !busCycle)
            multiplexed_bus_oe = 1'b1;
    end

    // Static latch mode; any strobed bus cycle gives the bus back.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            staticLatch_r <= RST_BUS;
            staticDrive_r <= 1'b0;
        end
        else if (phase_r == PH_ALE && curKind_r == KIND_LATCH)
        begin
            staticLatch_r <= curData_r;
            staticDrive_r <= 1'b1;
        end
        else if (phase_r == PH_ALE && busCycle)
            staticDrive_r <= 1'b0;
    end

    // Read data is taken in the last strobe phase, while the outside drives.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rdData_r <= RST_BUS;
            rdValid_r <= 1'b0;
        end
        else
        begin
            rdValid_r <= (phase_r == PH_STB2) && isRead;
            if (phase_r == PH_STB2 && isRead)
                rdData_r <= multiplexed_bus_in;
        end
    end
    assign rdData = rdData_r;
    assign rdValid = rdValid_r;

    // Port two: PC high bits for external fetches, expander nibble low.
    // Quasi-bidirectional bits drive low hard and release for a one.
    always_comb
    begin
        port_two_pins_out = portTwoLatch;
        port_two_pins_oe = ~portTwoLatch;
        if (extFetch)
        begin
            port_two_pins_out[7:4] = curAddr_r[11:8];
            port_two_pins_oe[7:4] = 4'hf;
        end
        if (curKind_r == KIND_EXPAND)
        begin
            port_two_pins_out[3:0] = stbPhase ? curData_r[3:0]
                : curAddr_r[3:0];
            port_two_pins_oe[3:0] = 4'hf;
        end
    end

    // Single step wait: entered only once the last cycle of an
    // instruction has run; a brief high on the input steps once more.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            stepWait_r <= 1'b0;
        else if (singleStepN)
            stepWait_r <= 1'b0;
        else if (phase_r == PH_STB2 && curLast_r)
            stepWait_r <= 1'b1;
    end
    assign stepWaiting = stepWait_r;

    // Power down is only entered at a cycle boundary, and only reset
    // leaves it, so no bus cycle is ever cut short.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            powerDown_r <= 1'b0;
        else if (powerDownCmd && phase_r == PH_REL)
            powerDown_r <= 1'b1;
    end
    assign powerDown = powerDown_r;
    assign oscStop = powerDown_r && !power_save_n;
    assign coreInit = rst;

    // Interrupt enable and request; the enable clears on reset.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            intEnable_r <= 1'b0;
            irqRequest_r <= 1'b0;
            intPinLow_r <= 1'b0;
        end
        else
        begin
            if (intEnableSet)
                intEnable_r <= 1'b1;
            else if (intEnableClr)
                intEnable_r <= 1'b0;
            irqRequest_r <= intEnable_r && !interruptN;
            intPinLow_r <= !interruptN;
        end
    end
    assign irqRequest = irqRequest_r;
    assign intPinLow = intPinLow_r;

    // Event counting on falling edges of test pin one.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            countMode_r <= 1'b0;
            t1Prev_r <= 1'b0;
            eventTick_r <= 1'b0;
        end
        else
        begin
            if (begin_event_counting)
                countMode_r <= 1'b1;
            else if (stopEventCounting)
                countMode_r <= 1'b0;
            t1Prev_r <= test_pin_one;
            eventTick_r <= countMode_r && t1Prev_r
                && !test_pin_one;
        end
    end
    assign eventTick = eventTick_r;
    assign t1Level = test_pin_one;

    // Test pin zero clock; once enabled only reset turns it back to input.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            t0ClkMode_r <= 1'b0;
            t0Clk_r <= 1'b0;
            t0Div_r <= 4'h0;
        end
        else
        begin
            if (enable_test_clock_out)
                t0ClkMode_r <= 1'b1;
            if (t0Div_r == T0_HALF_CYCLES - 4'h1)
            begin
                t0Div_r <= 4'h0;
                t0Clk_r <= !t0Clk_r;
            end
            else
                t0Div_r <= t0Div_r + 4'h1;
        end
    end
    assign test_pin_zero_out = t0Clk_r;
    assign test_pin_zero_oe = t0ClkMode_r;
    assign t0Level = test_pin_zero_in;

    // Checks.
    sequence s_ale_low4;
        !addressLatch [*4];
    endsequence

    property p_ale_period;
        @(posedge sys_clk) disable iff (rst)
        $fell(addressLatch) |-> s_ale_low4 ##0 1'b1;
    endproperty
    a_ale_period: assert property (p_ale_period)
        else $error("ALE pulse spacing wrong");

    property p_addr_at_fall;
        @(posedge sys_clk) disable iff (rst)
        $fell(addressLatch) && addrCycle |-> multiplexed_bus_oe
            && multiplexed_bus_out == curAddr_r[7:0];
    endproperty
    a_addr_at_fall: assert property (p_addr_at_fall)
        else $error("Address not valid at ALE fall");

    property p_fetch_ext_only;
        @(posedge sys_clk) disable iff (rst)
        !program_fetch_strobe_n |-> curKind_r == KIND_FETCH && curExt_r;
    endproperty
    a_fetch_ext_only: assert property (p_fetch_ext_only)
        else $error("Fetch strobe outside external fetch");

    sequence s_fetch_strobe;
        !program_fetch_strobe_n [*2] ##1 program_fetch_strobe_n;
    endsequence

    property p_fetch_seq;
        @(posedge sys_clk) disable iff (rst)
        addressLatch && extFetch |-> ##2 s_fetch_strobe ##0 rdValid;
    endproperty
    a_fetch_seq: assert property (p_fetch_seq)
        else $error("External fetch sequence wrong");

    property p_pc_high;
        @(posedge sys_clk) disable iff (rst)
        !program_fetch_strobe_n |-> port_two_pins_out[7:4] == curAddr_r[11:8];
    endproperty
    a_pc_high: assert property (p_pc_high)
        else $error("PC high bits missing on port two");

    property p_read_float;
        @(posedge sys_clk) disable iff (rst)
        !readStrobeN |-> !multiplexed_bus_oe;
    endproperty
    a_read_float: assert property (p_read_float)
        else $error("Bus driven during read strobe");

    property p_write_data;
        @(posedge sys_clk) disable iff (rst)
        !writeStrobeN |-> multiplexed_bus_oe
            && multiplexed_bus_out == curData_r;
    endproperty
    a_write_data: assert property (p_write_data)
        else $error("Write data not on bus under write strobe");

    property p_force_ext;
        @(posedge sys_clk) disable iff (rst)
        cmdTaken && cmdKind == KIND_FETCH && external_fetch_force
            |=> ##2 !program_fetch_strobe_n;
    endproperty
    a_force_ext: assert property (p_force_ext)
        else $error("Forced fetch stayed internal");

    property p_step_wait;
        @(posedge sys_clk) disable iff (rst)
        $rose(stepWait_r) |-> $past(curLast_r) && phase_r == PH_REL;
    endproperty
    a_step_wait: assert property (p_step_wait)
        else $error("Single step wait mid-instruction");

    property p_irq;
        @(posedge sys_clk) disable iff (rst)
        !intEnable_r |=> !irqRequest_r;
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt requested while disabled");

    property p_float;
        @(posedge sys_clk) disable iff (rst)
        multiplexed_bus_oe |-> program_fetch_strobe_n && readStrobeN
            && (addrCycle || !writeStrobeN || staticDrive_r);
    endproperty
    a_float: assert property (p_float)
        else $error("Bus driven without cause");

endmodule

// >>> rtl/mebi_pkg.sv
package mebi_pkg;

    // Bus cycle kinds that the core requests once per machine cycle.
    localparam logic [2:0] KIND_IDLE = 3'h0;
    localparam logic [2:0] KIND_FETCH = 3'h1;
    localparam logic [2:0] KIND_DATA_RD = 3'h2;
    localparam logic [2:0] KIND_DATA_WR = 3'h3;
    localparam logic [2:0] KIND_PORT_RD = 3'h4;
    localparam logic [2:0] KIND_PORT_WR = 3'h5;
    localparam logic [2:0] KIND_LATCH = 3'h6;
    localparam logic [2:0] KIND_EXPAND = 3'h7;

    // Widths of the program counter and the two buses.
    localparam int PC_W = 12;
    localparam int BUS_W = 8;
    localparam int NIB_W = 4;

    // Fetches at or above this address leave the internal program store.
    localparam logic [11:0] INT_EXPANDER_STROBE_LIMIT = 12'h800;

    // Half period of the test clock on test pin zero, in sys_clk cycles.
    localparam logic [3:0] T0_HALF_CYCLES = 4'h2;

    // Values after reset.
    localparam logic [7:0] RST_BUS = 8'h00;
    localparam logic [7:0] RST_PORT_TWO = 8'hff;

    // One machine cycle: five phases, one-hot.
    typedef enum logic [4:0] {
        PH_ALE  = 5'h01,
        PH_HOLD = 5'h02,
        PH_STB1 = 5'h04,
        PH_STB2 = 5'h08,
        PH_REL  = 5'h10
    } mebi_phase_e;

endpackage

// >>> dv/mebi_ext_mem.sv
// External program memory and data memory on the multiplexed bus.
module mebi_ext_mem (
    // Clock.
    input wire logic sys_clk,
    // Strobes from the device.
    input wire logic addressLatch,
    input wire logic program_fetch_strobe_n,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    // Device side of the bus and the high program counter bits.
    input wire logic [7:0] busOut,
    input wire logic busOe,
    input wire logic [3:0] pcHigh,
    // Resolved bus level seen by everybody.
    output logic [7:0] busLevel
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] latchedAddr;
    logic [7:0] lastLevel = 8'h00;
    logic [7:0] dataMem [256];
    logic [11:0] fetchAddr;

    // The address is taken in the last cycle before the strobe falls.
    always @(posedge sys_clk)
    begin
        if (addressLatch)
            latchedAddr <= busLevel;
        if (!writeStrobeN)
            dataMem[latchedAddr] <= busLevel;
        lastLevel <= busLevel;
    end

    // Released lines show the inverse of the last level, so a device
    // that samples a floating bus cannot pass by luck.
    always_comb
    begin
        fetchAddr = {pcHigh, latchedAddr};
        if (busOe)
            busLevel = busOut;
        else if (!program_fetch_strobe_n)
            busLevel = fetchAddr[7:0] ^ {2{fetchAddr[11:8]}};
        else if (!readStrobeN)
            busLevel = dataMem[latchedAddr];
        else
            busLevel = ~lastLevel;
    end
endmodule

// >>> dv/tb_mcu_external_bus_interface.sv
module tb_mcu_external_bus_interface;
    import mebi_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk, rst, cmdValid, cmdLast, cmdTaken, rdValid, coreInit;
    logic [2:0] cmdKind;
    logic [11:0] cmdAddr;
    logic [7:0] cmdData, rdData, portTwoLatch;
    logic intEnableSet, intEnableClr, enable_test_clock_out;
    logic begin_event_counting, stopEventCounting, powerDownCmd;
    logic irqRequest, intPinLow, t0Level, t1Level, eventTick;
    logic stepWaiting, powerDown, oscStop;
    logic [7:0] multiplexed_bus_in, multiplexed_bus_out;
    logic multiplexed_bus_oe, addressLatch, program_fetch_strobe_n;
    logic readStrobeN, writeStrobeN, expander_strobe;
    logic [7:0] port_two_pins_out, port_two_pins_oe;
    logic external_fetch_force, singleStepN, interruptN, power_save_n;
    logic test_pin_zero_in, test_pin_zero_out, test_pin_zero_oe;
    logic test_pin_one;
    int miscompares = 0;
    int checks_done = 0;
    int aleCnt, fetchCnt, rdCnt, wrCnt, expCnt, n;
    logic [7:0] p2c1, p2c3, busC5, p2oeC3;
    logic rdSeen, oeC5, prevT0;

    mebi_top dut (.sys_clk, .rst, .cmdValid, .cmdKind, .cmdAddr, .cmdData,
        .cmdLast, .cmdTaken, .rdData, .rdValid, .coreInit, .intEnableSet,
        .intEnableClr, .portTwoLatch, .enable_test_clock_out,
        .begin_event_counting, .stopEventCounting, .powerDownCmd,
        .irqRequest, .intPinLow, .t0Level, .t1Level, .eventTick,
        .stepWaiting, .powerDown, .oscStop, .multiplexed_bus_in,
        .multiplexed_bus_out, .multiplexed_bus_oe, .addressLatch,
        .program_fetch_strobe_n, .readStrobeN, .writeStrobeN,
        .expander_strobe, .port_two_pins_out, .port_two_pins_oe,
        .external_fetch_force, .singleStepN, .interruptN, .power_save_n,
        .test_pin_zero_in, .test_pin_zero_out, .test_pin_zero_oe,
        .test_pin_one);

    mebi_ext_mem mem (.sys_clk, .addressLatch, .program_fetch_strobe_n,
        .readStrobeN, .writeStrobeN, .busOut(multiplexed_bus_out),
        .busOe(multiplexed_bus_oe), .pcHigh(port_two_pins_out[7:4]),
        .busLevel(multiplexed_bus_in));

    // Free running 10 MHz clock.
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic check_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t value got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus cycle; strobe samples are counted over the five phases.
    task automatic run_cycle(input logic [2:0] kind, input logic [11:0] addr,
        input logic [7:0] data, input logic last);
        {aleCnt, fetchCnt, rdCnt, wrCnt, expCnt, n} = '0;
        cmdKind = kind;
        cmdAddr = addr;
        cmdData = data;
        cmdLast = last;
        cmdValid = 1'b1;
        #1;
        while (cmdTaken !== 1'b1 && n < 20)
        begin
            tick();
            #1;
            n++;
        end
        check_bit(cmdTaken, 1'b1);
        tick();
        cmdValid = 1'b0;
        for (int c = 1; c <= 5; c++)
        begin
            #1;
            aleCnt += (addressLatch === 1'b1);
            fetchCnt += (program_fetch_strobe_n === 1'b0);
            rdCnt += (readStrobeN === 1'b0);
            wrCnt += (writeStrobeN === 1'b0);
            expCnt += (expander_strobe === 1'b1);
            if (c == 1)
                p2c1 = port_two_pins_out;
            if (c == 3)
            begin
                p2c3 = port_two_pins_out;
                p2oeC3 = port_two_pins_oe;
            end
            rdSeen = rdValid;
            oeC5 = multiplexed_bus_oe;
            busC5 = multiplexed_bus_out;
            tick();
        end
    endtask

    // Forced external fetch, then an internal one that must stay silent.
    task automatic test_fetch();
        external_fetch_force = 1'b1;
        run_cycle(KIND_FETCH, 12'h123, 8'h00, 1'b0);
        check_val(aleCnt, 8'h01);
        check_val(fetchCnt, 8'h02);
        check_val(p2c3[7:4], 8'h01);
        check_val(p2oeC3, 8'hf0);
        check_bit(rdSeen, 1'b1);
        check_val(rdData, 8'h32);
        external_fetch_force = 1'b0;
        run_cycle(KIND_FETCH, 12'h045, 8'h00, 1'b0);
        check_val(aleCnt, 8'h01);
        check_val(fetchCnt + rdCnt, 8'h00);
    endtask

    // Data store then load through the external data memory.
    task automatic test_data();
        run_cycle(KIND_DATA_WR, 12'h03c, 8'ha5, 1'b0);
        check_val(wrCnt, 8'h02);
        check_val(fetchCnt + rdCnt, 8'h00);
        run_cycle(KIND_DATA_RD, 12'h03c, 8'h00, 1'b0);
        check_val(rdCnt, 8'h02);
        check_val(rdData, 8'ha5);
        check_bit(oeC5, 1'b0);
    endtask

    // Expander nibbles, then a statically latched bus value.
    task automatic test_expander_latch();
        run_cycle(KIND_EXPAND, 12'h006, 8'h09, 1'b0);
        check_val(expCnt, 8'h02);
        check_val(p2c1[3:0], 8'h06);
        check_val(p2c3[3:0], 8'h09);
        check_val(p2oeC3, 8'h0f);
        run_cycle(KIND_LATCH, 12'h000, 8'h7e, 1'b0);
        check_bit(oeC5, 1'b1);
        check_val(busC5, 8'h7e);
        // A strobed port write must take the bus back from the latch.
        run_cycle(KIND_PORT_WR, 12'h000, 8'h5a, 1'b0);
        check_val(wrCnt, 8'h02);
        check_bit(oeC5, 1'b0);
        run_cycle(KIND_PORT_RD, 12'h000, 8'h00, 1'b0);
        check_val(rdCnt + fetchCnt, 8'h02);
        check_bit(rdSeen, 1'b1);
    endtask

    // Single step halts after the last cycle and refuses new commands.
    task automatic test_step();
        singleStepN = 1'b0;
        run_cycle(KIND_IDLE, 12'h000, 8'h00, 1'b1);
        check_bit(stepWaiting, 1'b1);
        aleCnt = 0;
        cmdValid = 1'b1;
        repeat (10)
        begin
            tick();
            aleCnt += (addressLatch !== 1'b0) + (cmdTaken !== 1'b0);
        end
        check_val(aleCnt, 8'h00);
        cmdValid = 1'b0;
        singleStepN = 1'b1;
        repeat (12) tick();
    endtask

    // Interrupt stays masked until enabled, then masked again.
    task automatic test_irq();
        interruptN = 1'b0;
        repeat (3) tick();
        check_bit(irqRequest, 1'b0);
        check_bit(intPinLow, 1'b1);
        intEnableSet = 1'b1;
        tick();
        intEnableSet = 1'b0;
        repeat (2) tick();
        check_bit(irqRequest, 1'b1);
        intEnableClr = 1'b1;
        tick();
        intEnableClr = 1'b0;
        repeat (2) tick();
        check_bit(irqRequest, 1'b0);
        interruptN = 1'b1;
    endtask

    // Event counting on test pin one and the clock on test pin zero.
    task automatic test_pins();
        test_pin_one = 1'b1;
        test_pin_zero_in = 1'b1;
        begin_event_counting = 1'b1;
        tick();
        begin_event_counting = 1'b0;
        tick();
        check_bit(t1Level, 1'b1);
        check_bit(t0Level, 1'b1);
        test_pin_one = 1'b0;
        n = 0;
        repeat (4)
        begin
            tick();
            n += (eventTick === 1'b1);
        end
        check_val(n, 8'h01);
        // Once counting stops, a further falling edge must not tick.
        stopEventCounting = 1'b1;
        test_pin_one = 1'b1;
        tick();
        stopEventCounting = 1'b0;
        test_pin_one = 1'b0;
        repeat (2) tick();
        check_bit(eventTick, 1'b0);
        enable_test_clock_out = 1'b1;
        tick();
        enable_test_clock_out = 1'b0;
        repeat (2) tick();
        check_bit(test_pin_zero_oe, 1'b1);
        prevT0 = test_pin_zero_out;
        n = 0;
        repeat (8)
        begin
            tick();
            n += (test_pin_zero_out !== prevT0);
            prevT0 = test_pin_zero_out;
        end
        check_val(n, 8'h04);
    endtask

    // Power down with saving requested; only reset brings it back.
    task automatic test_power();
        // The request is only taken at a cycle boundary, so hold it.
        power_save_n = 1'b0;
        powerDownCmd = 1'b1;
        n = 0;
        while (powerDown !== 1'b1 && n < 10)
        begin
            tick();
            n++;
        end
        powerDownCmd = 1'b0;
        check_bit(powerDown, 1'b1);
        check_bit(oscStop, 1'b1);
        rst = 1'b1;
        tick();
        check_bit(powerDown, 1'b0);
        check_bit(coreInit, 1'b1);
        rst = 1'b0;
        tick();
    endtask

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Cuts a hang short well after the sequence should have ended.
    initial
    begin
        #200000;
        miscompares++;
        complete_run();
    end

    // Reset for three cycles, then the scenarios in turn.
    initial
    begin
        {cmdValid, cmdLast, cmdKind, cmdAddr, cmdData} = '0;
        {intEnableSet, intEnableClr, enable_test_clock_out} = '0;
        {begin_event_counting, stopEventCounting, powerDownCmd} = '0;
        {external_fetch_force, test_pin_zero_in, test_pin_one} = '0;
        {singleStepN, interruptN, power_save_n} = 3'h7;
        portTwoLatch = 8'hff;
        rst = 1'b1;
        repeat (2) tick();
        #1;
        check_bit(coreInit, 1'b1);
        check_bit(multiplexed_bus_oe, 1'b0);
        check_bit(program_fetch_strobe_n & readStrobeN, 1'b1);
        tick();
        rst = 1'b0;
        test_fetch();
        test_data();
        test_expander_latch();
        test_step();
        test_irq();
        test_pins();
        test_power();
        complete_run();
    end
endmodule
